//--- src/pmx_mgr.sv
// pmx_mgr: bus slave, fault alerting, capture, nvm and start-up
// assumes pins asynchronous to clk; measurements written over wishbone
`timescale 1ns/1ns
`include "pmx_consts.svh"
// Behaviour
// R1: unmasked fault or warning pulls alert low; code alerts on ov, uv and cml faults only, no warnings
// R2: alert held until clear or re-enable
// R3: mask command keeps chosen faults off alert
// R4: capture command records measurements and status
// R5: selected faults store capture into nvm
// R6: standard bus protocol, device stretches clock
// R7: busy flag shown in status byte
// R8: host leaves bus-free time between transfers
// R9: packet error checking generated and checked
// R10: host waits after writes and stores
// R11: host waits after reads
// R12: protected default area, user area preloaded
// R13: store user copies working values to user
// R14: write protect mask guards user entries
// R15: ordered start-up: test, address, vout_strap_pin, nvm, sync
// R16: later start-up loads overwrite earlier ones
// R17: enable pin and bus honoured after init
// R18: undervoltage turn-on above turn-off threshold
// R19: latch off or auto restart on undervoltage
// R20: default undervoltage response is auto restart
// R21: uv limits and response are settable
// R22: overvoltage monitored with same responses
module pmx_mgr import pmx_pkg::*; #(
    parameter int INIT_CYC = `PMX_INIT_MS * 1000000 / `PMX_CLK_NS,
    parameter int NVM_CYC = `PMX_NVM_MS * 1000000 / `PMX_CLK_NS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic alert_line_o,
    output logic alert_line_oe_n,
    input wire logic [6:0] addr_strap_pin,
    input wire logic [7:0] vout_strap_pin,
    input wire logic ext_sync_pin,
    input wire logic output_enable_pin,
    output logic vout_en,
    output logic [7:0] vout_set,
    output logic sync_locked,
    output logic init_done
);
    localparam int NS = 10;
    localparam int NP = 19;
    localparam int SYNC_CYC = `PMX_SYNC_US * 1000 / `PMX_CLK_NS;
    localparam int STR_CYC =
        (`PMX_STRETCH_NS + `PMX_CLK_NS - 1) / `PMX_CLK_NS;
    localparam logic [79:0] CODES = `PMX_SLOT_CODES;
    localparam logic [79:0] DEFV = `PMX_DEF_NVM;

    logic [NP-1:0] pin_s1_q, pin_s2_q;
    logic scl_d_q, sda_d_q, sync_d_q, en_d_q;
    logic scl_s, sda_s, sync_s, en_s;
    logic [6:0] addr_s;
    logic [7:0] vout_strap_pin_s;
    pmx_bus_ev_t ev;
    pmx_init_t ist_q;
    logic [23:0] icnt_q, nbusy_q;
    logic [9:0] scnt_q;
    logic [6:0] addr_q;
    logic init_done_q, sync_locked_q, run, busy;
    logic [7:0] work_q [NS];
    logic [7:0] user_q [NS];
    logic [7:0] rdor [NS+1];
    logic [NS-1:0] hit, prot;
    logic act_q, inx_q, tx_q, rd_q, ack_q, sda_oe_n_q, scl_oe_n_q;
    logic [3:0] bitc_q;
    logic [2:0] bidx_q, str_q;
    logic [7:0] sh_q, txsh_q, cmd_q, data_q, crc_q;
    logic [7:0] byte_in, rd_val, stat_b, in_set, cml_set, stat_in_q, cml_q;
    logic is_send, x_go, pec_bad, do_wr, do_clear, do_stusr, do_rsdef;
    logic do_rsusr, do_snap, bad_cmd, reen, clr, cap, alert_ev;
    logic [2:0] nb_plain;
    logic uv_low, uv_ok, ov_high, ov_ok, uv_off_q, ov_off_q, uv_ev, ov_ev;
    logic alert_oe_n_q, vout_en_q, zero_q;
    logic [7:0] vout_set_q;
    pmx_meas_t meas_q;
    pmx_snap_t live, snap_q, nvsnap_q;
    logic wb_ack_q, wb_hit, wb_wr;
    logic [31:0] wb_dat_q, wb_rd_d;
    logic [2:0] wb_idx, wb_rgn;
    logic [5:0] mbit;
    logic [7:0] stat_w;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int k = 0; k < 8; k++) begin
            r = r[7] ? ((r << 1) ^ `PMX_PEC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] pick(input logic [55:0] v,
                                        input logic [2:0] i);
        return (i > 3'd6) ? 8'h00 : v[8 * (6 - int'(i)) +: 8];
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
            sync_d_q <= 1'b1;
            en_d_q <= 1'b1;
        end else begin
            pin_s1_q <= {vout_strap_pin, addr_strap_pin, output_enable_pin,
                         ext_sync_pin, sda_i, scl_i};
            pin_s2_q <= pin_s1_q;
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
            sync_d_q <= sync_s;
            en_d_q <= en_s;
        end
    end
    assign scl_s = pin_s2_q[0];
    assign sda_s = pin_s2_q[1];
    assign sync_s = pin_s2_q[2];
    assign en_s = pin_s2_q[3];
    assign addr_s = pin_s2_q[10:4];
    assign vout_strap_pin_s = pin_s2_q[18:11];
    assign ev = {scl_s & scl_d_q & sda_d_q & ~sda_s,
                 scl_s & scl_d_q & ~sda_d_q & sda_s,
                 scl_s & ~scl_d_q, ~scl_s & scl_d_q};
    assign reen = en_s & ~en_d_q;

    // ------------------------------------------------------------------
    // start-up sequence
    // ------------------------------------------------------------------
    assign run = (ist_q == I_RUN);
    assign busy = ~run | (nbusy_q != 24'd0);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ist_q <= I_SELF;
            icnt_q <= '0;
            scnt_q <= '0;
            addr_q <= '0;
            sync_locked_q <= 1'b0;
            init_done_q <= 1'b0;
        end else begin
            if (icnt_q != 24'(INIT_CYC)) icnt_q <= icnt_q + 24'd1;
            if (ist_q == I_WAIT && icnt_q == 24'(INIT_CYC))
                init_done_q <= 1'b1;
            case (ist_q) // R15
                // two cycles, so the strap synchronisers hold pin levels
                I_SELF: if (icnt_q != 24'd0) ist_q <= I_ADDR;
                I_ADDR: begin
                    addr_q <= addr_s;
                    ist_q <= I_VOUT_STRAP_PIN;
                end
                I_VOUT_STRAP_PIN: ist_q <= I_DEF;
                I_DEF: ist_q <= I_USER;
                I_USER: ist_q <= I_SYNC;
                I_SYNC: begin
                    scnt_q <= scnt_q + 10'd1;
                    if (sync_s != sync_d_q) sync_locked_q <= 1'b1;
                    if (sync_s != sync_d_q || scnt_q == 10'(SYNC_CYC))
                        ist_q <= I_WAIT;
                end
                I_WAIT: if (icnt_q == 24'(INIT_CYC)) ist_q <= I_RUN; // R17
                I_RUN: ist_q <= I_RUN;
                default: ist_q <= I_SELF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // working and user settings, one slot per command
    // ------------------------------------------------------------------
    assign rdor[0] = 8'h00;
    for (genvar gi = 0; gi < NS; gi++) begin : g_slot
        assign hit[gi] = (cmd_q == CODES[8 * gi +: 8]);
        assign rdor[gi + 1] = rdor[gi] | (hit[gi] ? work_q[gi] : 8'h00);
        if (gi < 8) begin : g_wp
            assign prot[gi] = work_q[`PMX_S_WP][gi];
        end else begin : g_nowp
            assign prot[gi] = 1'b0;
        end
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                work_q[gi] <= DEFV[8 * gi +: 8];
            end else if (gi == `PMX_S_VOUT && ist_q == I_VOUT_STRAP_PIN) begin
                work_q[gi] <= vout_strap_pin_s;
            end else if (ist_q == I_DEF || do_rsdef) begin // R16 R12
                work_q[gi] <= DEFV[8 * gi +: 8];
            end else if (ist_q == I_USER || do_rsusr) begin // R16
                work_q[gi] <= user_q[gi];
            end else if (do_wr && hit[gi]) begin // R3 R21 R17
                work_q[gi] <= data_q;
            end
        end
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) user_q[gi] <= DEFV[8 * gi +: 8]; // R12
            else if (do_stusr && !prot[gi]) user_q[gi] <= work_q[gi]; // R13 R14
        end
    end

    // ------------------------------------------------------------------
    // bus slave: bit engine, address match, pec
    // ------------------------------------------------------------------
    assign byte_in = {sh_q[6:0], sda_s};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_q <= 1'b0;
            inx_q <= 1'b0;
            tx_q <= 1'b0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            bitc_q <= '0;
            bidx_q <= '0;
            sh_q <= '0;
            txsh_q <= '0;
            cmd_q <= '0;
            data_q <= '0;
            crc_q <= '0;
        end else if (ev.start) begin
            act_q <= run; // R17
            inx_q <= 1'b1;
            tx_q <= 1'b0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            bitc_q <= '0;
            bidx_q <= '0;
            if (!inx_q) crc_q <= '0;
        end else if (ev.stop) begin
            act_q <= 1'b0;
            inx_q <= 1'b0;
            tx_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (ev.rise) begin
            if (bitc_q == 4'd8) begin
                bitc_q <= '0;
                ack_q <= 1'b0;
                if (bidx_q != 3'd7) bidx_q <= bidx_q + 3'd1;
                if (tx_q) begin
                    if (sda_s) tx_q <= 1'b0;
                    txsh_q <= crc_q; // R9
                end else if (act_q && rd_q && bidx_q == 3'd0) begin
                    tx_q <= 1'b1;
                end
            end else begin
                bitc_q <= bitc_q + 4'd1;
                sh_q <= byte_in;
            end
            if (bitc_q == 4'd7 && tx_q) begin
                crc_q <= crc8(crc_q, txsh_q); // R9
            end else if (bitc_q == 4'd7 && act_q) begin
                crc_q <= crc8(crc_q, byte_in); // R9
                ack_q <= (bidx_q != 3'd0) || (byte_in[7:1] == addr_q);
                if (bidx_q == 3'd0) begin
                    rd_q <= byte_in[0];
                    txsh_q <= rd_val;
                    if (byte_in[7:1] != addr_q) act_q <= 1'b0;
                end
                if (bidx_q == 3'd1) cmd_q <= byte_in;
                if (bidx_q == 3'd2) data_q <= byte_in;
            end
        end
    end

    // sda is driven on scl falls and released at start and stop, so data is steady while scl high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe_n_q <= 1'b1;
            str_q <= '0;
            scl_oe_n_q <= 1'b1;
            zero_q <= 1'b0;
        end else begin
            zero_q <= 1'b0;
            if (ev.start || ev.stop) sda_oe_n_q <= 1'b1;
            else if (ev.fall && bitc_q == 4'd8) sda_oe_n_q <= ~ack_q;
            else if (ev.fall && tx_q) sda_oe_n_q <= txsh_q[3'd7 - bitc_q[2:0]];
            else if (ev.fall) sda_oe_n_q <= 1'b1;
            if (ev.fall && act_q && bitc_q == 4'd8) begin // R6
                str_q <= 3'(STR_CYC);
                scl_oe_n_q <= 1'b0;
            end else if (str_q != 3'd0) begin
                str_q <= str_q - 3'd1;
                scl_oe_n_q <= (str_q == 3'd1);
            end
        end
    end

    // ------------------------------------------------------------------
    // command execution at stop
    // ------------------------------------------------------------------
    assign is_send = cmd_q == `PMX_C_CLEAR || cmd_q == `PMX_C_STDEF ||
        cmd_q == `PMX_C_RSDEF || cmd_q == `PMX_C_STUSR ||
        cmd_q == `PMX_C_RSUSR || cmd_q == `PMX_C_SNAP;
    assign nb_plain = is_send ? 3'd2 : 3'd3;
    assign x_go = ev.stop && act_q && !rd_q && !busy &&
        (bidx_q == nb_plain || (bidx_q == nb_plain + 3'd1 && crc_q == 8'h00));
    assign pec_bad = ev.stop && act_q && !rd_q &&
        bidx_q == nb_plain + 3'd1 && crc_q != 8'h00; // R9
    assign do_wr = x_go && !is_send && (|hit);
    assign do_clear = x_go && cmd_q == `PMX_C_CLEAR;
    assign do_stusr = x_go && cmd_q == `PMX_C_STUSR;
    assign do_rsdef = x_go && cmd_q == `PMX_C_RSDEF;
    assign do_rsusr = x_go && cmd_q == `PMX_C_RSUSR;
    assign do_snap = x_go && cmd_q == `PMX_C_SNAP;
    assign bad_cmd = x_go && (cmd_q == `PMX_C_STDEF || (!is_send && !(|hit)));
    assign rd_val = (cmd_q == `PMX_C_STATB) ? stat_b :
        (cmd_q == `PMX_C_STATIN) ? stat_in_q :
        (cmd_q == `PMX_C_STATCML) ? cml_q :
        (|hit) ? rdor[NS] : 8'hFF;

    // ------------------------------------------------------------------
    // input protection, status and alert
    // ------------------------------------------------------------------
    assign uv_low = meas_q.vin < work_q[`PMX_S_UVF];
    assign uv_ok = meas_q.vin > work_q[`PMX_S_UVW]; // R18
    assign ov_high = meas_q.vin > work_q[`PMX_S_OVF];
    assign ov_ok = meas_q.vin < work_q[`PMX_S_OVW];
    assign uv_ev = run && uv_low && !uv_off_q;
    assign ov_ev = run && ov_high && !ov_off_q;
    assign clr = do_clear || reen;
    assign in_set = (8'(ov_ev) << `PMX_IN_OVF) | (8'(uv_ev) << `PMX_IN_UVF);
    assign cml_set = (8'(bad_cmd) << `PMX_CML_BAD) |
        (8'(pec_bad) << `PMX_CML_PEC);
    assign alert_ev = |((in_set | (8'(|cml_set) << `PMX_B_CML)) &
        ~work_q[`PMX_S_ALM]); // R1 R3
    assign stat_b = (8'(busy) << `PMX_B_BUSY) | (8'(!vout_en_q) << `PMX_B_OFF)
        | (8'(|stat_in_q) << `PMX_B_VIN) | (8'(|cml_q) << `PMX_B_CML); // R7
    assign cap = |(in_set & work_q[`PMX_S_CAP]); // R5
    assign live = {meas_q, stat_b};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            uv_off_q <= 1'b0;
            ov_off_q <= 1'b0;
            stat_in_q <= '0;
            cml_q <= '0;
            alert_oe_n_q <= 1'b1;
            vout_en_q <= 1'b0;
            vout_set_q <= '0;
            nbusy_q <= '0;
            snap_q <= '0;
            nvsnap_q <= '0;
        end else begin
            if (uv_ev) uv_off_q <= 1'b1; // R19 R20
            else if (work_q[`PMX_S_UVR][`PMX_RESP_AUTO] ? uv_ok : clr)
                uv_off_q <= 1'b0;
            if (ov_ev) ov_off_q <= 1'b1; // R22
            else if (work_q[`PMX_S_OVR][`PMX_RESP_AUTO] ? ov_ok : clr)
                ov_off_q <= 1'b0;
            stat_in_q <= in_set | (clr ? 8'h00 : stat_in_q);
            cml_q <= cml_set | (clr ? 8'h00 : cml_q);
            if (alert_ev) alert_oe_n_q <= 1'b0; // R1
            else if (clr) alert_oe_n_q <= 1'b1; // R2
            vout_en_q <= init_done_q && en_s && !uv_off_q && !ov_off_q; // R17
            vout_set_q <= work_q[`PMX_S_VOUT];
            if (do_stusr || do_rsusr || do_rsdef || cap)
                nbusy_q <= 24'(NVM_CYC);
            else if (nbusy_q != 24'd0)
                nbusy_q <= nbusy_q - 24'd1;
            if (do_snap) snap_q <= live; // R4
            if (cap) nvsnap_q <= live; // R5
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    assign wb_idx = wb_adr_i[4:2];
    assign wb_rgn = wb_adr_i[7:5];
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0] &&
        wb_rgn == `PMX_RG_MEAS && wb_idx < 3'd6;
    assign mbit = {3'd5 - wb_idx, 3'b000};
    assign stat_w = {init_done_q, sync_locked_q, vout_en_q, busy,
        !alert_oe_n_q, uv_off_q, ov_off_q, 1'b0};
    assign wb_rd_d =
        (wb_rgn == `PMX_RG_MEAS && wb_idx == `PMX_IX_STAT) ? {24'h0, stat_w} :
        (wb_rgn == `PMX_RG_MEAS) ? {24'h0, pick({meas_q, 8'h00}, wb_idx)} :
        (wb_rgn == `PMX_RG_SNAP) ? {24'h0, pick(snap_q, wb_idx)} :
        (wb_rgn == `PMX_RG_NVSNAP) ? {24'h0, pick(nvsnap_q, wb_idx)} :
        32'h0000_0000;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= '0;
            meas_q <= '0;
        end else begin
            wb_ack_q <= wb_hit;
            wb_dat_q <= wb_hit ? wb_rd_d : 32'h0000_0000;
            if (wb_wr) meas_q[mbit +: 8] <= wb_dat_i[7:0];
        end
    end

    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;
    assign scl_o = zero_q;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_o = zero_q;
    assign sda_oe_n = sda_oe_n_q;
    assign alert_line_o = zero_q;
    assign alert_line_oe_n = alert_oe_n_q;
    assign vout_en = vout_en_q;
    assign vout_set = vout_set_q;
    assign sync_locked = sync_locked_q;
    assign init_done = init_done_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_alert_on;
        uv_ev && !work_q[`PMX_S_ALM][`PMX_IN_UVF] |=> !alert_oe_n_q;
    endproperty
    a_alert_on: assert property (p_alert_on) else $error("alert missed"); // R1
    property p_alert_hold;
        !alert_oe_n_q && !clr |=> !alert_oe_n_q;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert lost"); // R2
    property p_mask;
        alert_oe_n_q && !alert_ev |=> alert_oe_n_q;
    endproperty
    a_mask: assert property (p_mask) else $error("masked alert"); // R3
    property p_snap;
        do_snap |=> snap_q == $past(live);
    endproperty
    a_snap: assert property (p_snap) else $error("capture wrong"); // R4
    property p_cap;
        cap |=> nvsnap_q == $past(live) && busy;
    endproperty
    a_cap: assert property (p_cap) else $error("fault capture"); // R5
    property p_busy;
        do_stusr |=> stat_b[`PMX_B_BUSY] [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not shown"); // R7
    property p_pec;
        pec_bad |=> cml_q[`PMX_CML_PEC] && !$past(do_wr);
    endproperty
    a_pec: assert property (p_pec) else $error("pec not flagged"); // R9
    property p_store;
        do_stusr && !prot[0] |=> user_q[0] == $past(work_q[0]);
    endproperty
    a_store: assert property (p_store) else $error("store failed"); // R13
    property p_order;
        ist_q == I_VOUT_STRAP_PIN |=> ist_q == I_DEF ##1 ist_q == I_USER;
    endproperty
    a_order: assert property (p_order) else $error("init order"); // R15
    property p_gate;
        !init_done_q |-> !vout_en_q && !(ev.start && run);
    endproperty
    a_gate: assert property (p_gate) else $error("early enable"); // R17
    property p_hyst;
        uv_off_q && work_q[`PMX_S_UVR][`PMX_RESP_AUTO] && !uv_ok
            |=> uv_off_q;
    endproperty
    a_hyst: assert property (p_hyst) else $error("uv hysteresis"); // R18
    property p_ov;
        ov_ev |=> ov_off_q ##1 !vout_en_q;
    endproperty
    a_ov: assert property (p_ov) else $error("ov not off"); // R22
endmodule // pmx_mgr

//--- src/pmx_consts.svh
// pmx_consts.svh: offsets, codes, reset values and timing of the manager
// assumes a 10 MHz core clock and byte-wide command values
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PMX_CLK_NS 100
`define PMX_INIT_MS 20
`define PMX_NVM_MS 50
`define PMX_SYNC_US 100
`define PMX_STRETCH_NS 400
// ----------------------------------------------------------------------
// wishbone map: region in adr[7:5], word index in adr[4:2]
// ----------------------------------------------------------------------
`define PMX_RG_MEAS 3'h0
`define PMX_RG_SNAP 3'h1
`define PMX_RG_NVSNAP 3'h2
`define PMX_IX_STAT 3'h6
// ----------------------------------------------------------------------
// bus command codes
// ----------------------------------------------------------------------
`define PMX_C_CLEAR 8'h03
`define PMX_C_STDEF 8'h11
`define PMX_C_RSDEF 8'h12
`define PMX_C_STUSR 8'h15
`define PMX_C_RSUSR 8'h16
`define PMX_C_STATB 8'h78
`define PMX_C_STATIN 8'h7C
`define PMX_C_STATCML 8'h7E
`define PMX_C_SNAP 8'hD7
// codes of the ten stored settings, slot 9 in the top byte
`define PMX_SLOT_CODES 80'hE2D8_DB56_5755_5A58_5921
// factory values of the ten slots, slot 9 in the top byte
`define PMX_DEF_NVM 80'h0091_00C0_C0C8_C068_6064
`define PMX_S_VOUT 0
`define PMX_S_UVF 1
`define PMX_S_UVW 2
`define PMX_S_UVR 3
`define PMX_S_OVF 4
`define PMX_S_OVW 5
`define PMX_S_OVR 6
`define PMX_S_ALM 7
`define PMX_S_CAP 8
`define PMX_S_WP 9
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PMX_RESP_AUTO 6
`define PMX_IN_OVF 7
`define PMX_IN_UVF 4
`define PMX_CML_BAD 7
`define PMX_CML_PEC 5
`define PMX_B_BUSY 7
`define PMX_B_OFF 6
`define PMX_B_VIN 3
`define PMX_B_CML 1
`define PMX_PEC_POLY 8'h07
`endif

//--- src/pmx_pkg.sv
// pmx_pkg: types shared by the power manager
// assumes byte-wide measurement codes
package pmx_pkg;
    typedef struct packed {
        logic [7:0] vin;
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] temp;
        logic [7:0] freq;
        logic [7:0] duty;
    } pmx_meas_t;
    typedef struct packed {
        pmx_meas_t meas;
        logic [7:0] stat;
    } pmx_snap_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } pmx_bus_ev_t;
    typedef enum logic [2:0] {
        I_SELF = 3'b000,
        I_ADDR = 3'b001,
        I_VOUT_STRAP_PIN = 3'b010,
        I_DEF = 3'b011,
        I_USER = 3'b100,
        I_SYNC = 3'b101,
        I_WAIT = 3'b110,
        I_RUN = 3'b111
    } pmx_init_t;
endpackage

//--- testbench/pmx_host_model.sv
// pmx_host_model: bit-banged bus host, pull-ups on scl and sda
// assumes the device drives only its active-low enables
`timescale 1ns/1ns
module pmx_host_model (
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda
);
    logic scl_h = 1'b1;
    logic sda_h = 1'b1;
    assign scl = scl_h & scl_oe_n;
    assign sda = sda_h & sda_oe_n;
    task automatic bit_io(input logic b, output logic r);
        sda_h = b;
        #200 scl_h = 1'b1;
        while (scl !== 1'b1) #100;
        #200 r = sda;
        #200 scl_h = 1'b0;
        #200;
    endtask
    task automatic send(input logic [7:0] q[$], output logic nak);
        logic r;
        nak = 1'b0;
        #400 sda_h = 1'b0;
        #400 scl_h = 1'b0;
        foreach (q[i]) begin
            for (int k = 7; k >= 0; k--) bit_io(q[i][k], r);
            bit_io(1'b1, r);
            nak = nak | r;
        end
        sda_h = 1'b0;
        #200 scl_h = 1'b1;
        while (scl !== 1'b1) #100;
        #400 sda_h = 1'b1;
        #4700;
    endtask
endmodule // pmx_host_model

//--- testbench/pmx_mgr_tb_top.sv
// pmx_mgr_tb_top: wishbone and bus host stimulus with self checks
// assumes a 10 MHz clock and shortened init and nvm counts
`timescale 1ns/1ns
module pmx_mgr_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic [7:0] vout_set;
    logic ack, scl, sda, scl_oe_n, sda_oe_n, alert_oe_n, vout_en, nak;
    logic init_done, sync_locked;
    logic en_pin = 1'b1;
    logic sync_pin = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    // address, write data, expected read back
    logic [23:0] rows [7] = '{24'h0070_70, 24'h0422_22, 24'h0833_33,
        24'h0C44_44, 24'h1055_55, 24'h1466_66, 24'hFC5A_00};
    always #50 clk = ~clk;
    pmx_mgr #(.INIT_CYC(200), .NVM_CYC(16)) dut (
        .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .scl_o(),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n),
        .alert_line_o(), .alert_line_oe_n(alert_oe_n),
        .addr_strap_pin(7'h2A), .vout_strap_pin(8'h33),
        .ext_sync_pin(sync_pin), .output_enable_pin(en_pin),
        .vout_en(vout_en), .vout_set(vout_set),
        .sync_locked(sync_locked), .init_done(init_done));
    pmx_host_model host (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
        .scl(scl), .sda(sda));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [31:0] r);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0000_00, d};
        sel <= 4'h1;
        @(posedge clk);
        while (ack !== 1'b1 && t < 20) begin
            @(posedge clk);
            t++;
        end
        chk(t < 20, 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sb(input logic [7:0] q[$]);
        host.send(q, nak);
        chk(nak, 1'b0);
        repeat (6) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #3000000;
        n_errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] r;
        repeat (2) @(posedge clk);
        chk({init_done, ack, alert_oe_n}, 3'b001);
        reset_n <= 1'b1;
        for (int i = 0; i < 1500 && init_done !== 1'b1; i++) begin
            @(posedge clk);
            if (i == 20) sync_pin <= 1'b1;
        end
        chk({init_done, sync_locked}, 2'b11);
        chk(vout_set, 8'h64);
        foreach (rows[i]) begin
            wb(1'b1, rows[i][23:16], rows[i][15:8], r);
            wb(1'b0, rows[i][23:16], 8'h00, r);
            chk(r, {24'h0000_00, rows[i][7:0]});
        end
        $display("register rows done");
        sb({8'h54, 8'h03});
        chk({alert_oe_n, vout_en}, 2'b11);
        sb({8'h54, 8'hD7});
        wb(1'b0, 8'h20, 8'h00, r);
        chk(r, 32'h0000_0070);
        wb(1'b0, 8'h34, 8'h00, r);
        chk(r, 32'h0000_0066);
        $display("capture done");
        wb(1'b1, 8'h00, 8'hD0, r);
        repeat (6) @(posedge clk);
        chk({alert_oe_n, vout_en}, 2'b00);
        wb(1'b1, 8'h00, 8'h50, r);
        repeat (6) @(posedge clk);
        chk({alert_oe_n, vout_en}, 2'b00);
        wb(1'b1, 8'h00, 8'h70, r);
        repeat (20) @(posedge clk);
        chk({alert_oe_n, vout_en}, 2'b01);
        wb(1'b0, 8'h40, 8'h00, r);
        chk(r, 32'h0000_0050);
        sb({8'h54, 8'h03});
        chk(alert_oe_n, 1'b1);
        $display("undervoltage done");
        sb({8'h54, 8'hDB, 8'h10});
        wb(1'b1, 8'h00, 8'h50, r);
        repeat (6) @(posedge clk);
        chk({alert_oe_n, vout_en}, 2'b10);
        $display("alert mask done");
        sb({8'h54, 8'h21, 8'h22, 8'hDB});
        chk({alert_oe_n, vout_set}, 9'h064);
        en_pin <= 1'b0;
        repeat (8) @(posedge clk);
        en_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk(alert_oe_n, 1'b1);
        sb({8'h54, 8'h21, 8'h22, 8'hDA});
        chk(vout_set, 8'h22);
        sb({8'h54, 8'h15});
        sb({8'h54, 8'h12});
        chk(vout_set, 8'h64);
        sb({8'h54, 8'h16});
        chk(vout_set, 8'h22);
        $display("pec and nvm done");
        end_of_test();
    end
endmodule // pmx_mgr_tb_top
